// >>> core/odlc_pkg.sv
// Overview of operation
// R1: Lock pin follows PLL lock when select top clear
// R2: Test select resets to lock indication
// R3: Codes 100-111 route xtal or halved clocks
// R4: Prescaler divides by 5 through 11
// R5: Output dividers span 1 to 1023
// R6: Host writes driver control registers to configure
// R7: Bit 0 picks strap or register mode
// R8: Mode 000 is CMOS, both pins driving
// R9: Modes 001/010/011 tristate negative/positive/both
// R10: 100 LVDS, 101 LVPECL, both pins driving
// R11: Strap 000..011 decode to per-output modes
// R12: Strap 100..111 decode to per-output modes
// R13: Strapped CMOS complementary pin copies true pin
// R14: Bit 2 sets CMOS polarity
// R15: Bit 7 sets weak or strong drive for CMOS and LVDS only
// R16: Bit 6 powers the driver down
// R17: Outputs static during VCO calibration
// R18: Unused modes tristate both pins
package odlc_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_LOCK_SEL  = 8'h17;
  localparam logic [7:0] ADDR_DRV1_CTRL = 8'h32;
  localparam logic [7:0] ADDR_DRV2_CTRL = 8'h34;
  localparam logic [7:0] RST_LOCK_SEL   = 8'h00;
  localparam logic [7:0] RST_DRV_CTRL   = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // ==========================================================
  // Field positions
  localparam int SEL_LSB   = 1;
  localparam int SEL_MSB   = 3;
  localparam int CTL_SRC   = 0;
  localparam int CTL_POL   = 2;
  localparam int MODE_LSB  = 3;
  localparam int MODE_MSB  = 5;
  localparam int CTL_PD    = 6;
  localparam int CTL_DRIVE = 7;

  // ==========================================================
  // Lock pin sources
  localparam logic [2:0] TP_XTAL = 3'h0_4;
  localparam logic [2:0] TP_PUMP = 3'h0_5;
  localparam logic [2:0] TP_REF  = 3'h0_6;
  localparam logic [2:0] TP_FB   = 3'h0_7;

  // ==========================================================
  // Driver modes
  localparam logic [2:0] MODE_CMOS_BOTH = 3'h0_0;
  localparam logic [2:0] MODE_CMOS_POS  = 3'h0_1;
  localparam logic [2:0] MODE_CMOS_NEG  = 3'h0_2;
  localparam logic [2:0] MODE_CMOS_OFF  = 3'h0_3;
  localparam logic [2:0] MODE_LVDS      = 3'h0_4;
  localparam logic [2:0] MODE_LVPECL    = 3'h0_5;

  typedef enum logic [1:0] {
    ODLC_FAM_CMOS   = 2'h0,
    ODLC_FAM_LVDS   = 2'h1,
    ODLC_FAM_LVPECL = 2'h3,
    ODLC_FAM_NONE   = 2'h2
  } odlc_family_t;

  // ==========================================================
  // Divider ranges
  localparam logic [3:0] PRESC_MIN = 4'h5;
  localparam logic [3:0] PRESC_MAX = 4'hb;
  localparam int         PX_W   = 10;
endpackage

// >>> core/odlc_divider.sv
`timescale 1ns/1ps
`default_nettype none
module odlc_divider #(
  parameter int W = 10
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         in_tick,
  input  wire logic [W-1:0] ratio,
  output logic              out_tick,
  output logic              out_level
);
  import odlc_pkg::*;

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic [W-1:0] eff;
  logic         wrap;

  // Zero is treated as one so the output never stops
  assign eff  = (ratio == '0) ? W'(1) : ratio;
  assign wrap = (count_r >= eff - W'(1));
  assign count_nxt = wrap ? '0 : count_r + W'(1);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      count_r   <= '0;
      out_tick  <= 1'b0;
      out_level <= 1'b0;
    end
    else if (ce)
    begin
      out_tick <= in_tick & wrap;
      if (in_tick)
      begin
        count_r   <= count_nxt;
        // Ratio one simply passes the input through
        out_level <= (eff == W'(1)) ? 1'b1 : (count_nxt < (eff >> 1));
      end
      else if (eff == W'(1))
        out_level <= 1'b0;
    end
  end

  chk_div_tick: assert property (@(posedge clk) disable iff (rst)
    (ce && in_tick && ratio == W'(1)) |=> out_tick)
    else $error("divide by one missed a tick");
endmodule // odlc_divider
`default_nettype wire

// >>> core/odlc_output_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module odlc_output_ctrl #(
  parameter int PX_WIDTH = odlc_pkg::PX_W
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  input  wire logic                 reg_wr_en,
  input  wire logic                 reg_rd_en,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic [7:0]                reg_rdata,
  input  wire logic                 pll_locked,
  input  wire logic                 xtal_clk,
  input  wire logic                 phase_detector_pump_up_clk,
  input  wire logic                 phase_detector_ref_clk,
  input  wire logic                 phase_detector_fb_clk,
  output logic                      lock_pin,
  input  wire logic                 vco_tick,
  input  wire logic [3:0]           vco_prescaler_ratio,
  input  wire logic [PX_WIDTH-1:0]  first_output_divider_ratio,
  input  wire logic [PX_WIDTH-1:0]  second_output_divider_ratio,
  input  wire logic [2:0]           output_mode_strap_pins,
  input  wire logic                 vco_cal_active,
  output logic                      first_clock_output_p,
  output logic                      first_clock_output_p_oe,
  output logic                      first_clock_output_n,
  output logic                      first_clock_output_n_oe,
  output odlc_pkg::odlc_family_t    first_clock_output_family,
  output logic                      first_clock_output_strong,
  output logic                      second_clock_output_p,
  output logic                      second_clock_output_p_oe,
  output logic                      second_clock_output_n,
  output logic                      second_clock_output_n_oe,
  output odlc_pkg::odlc_family_t    second_clock_output_family,
  output logic                      second_clock_output_strong
);
  import odlc_pkg::*;

  // ==========================================================
  // Strap decoder, both outputs in one word
  function automatic logic [5:0] strap_decode(input logic [2:0] s);
    case (s)
      3'h0_0: strap_decode = {MODE_LVPECL, MODE_LVPECL};   // R11
      3'h0_1: strap_decode = {MODE_LVPECL, MODE_LVDS};     // R11
      3'h0_2: strap_decode = {MODE_LVDS, MODE_LVPECL};     // R11
      3'h0_3: strap_decode = {MODE_LVPECL, MODE_CMOS_POS}; // R11
      3'h0_4: strap_decode = {MODE_LVDS, MODE_LVDS};       // R12
      3'h0_5: strap_decode = {MODE_LVDS, MODE_CMOS_POS};   // R12
      3'h0_6: strap_decode = {MODE_CMOS_POS, MODE_LVDS};   // R12
      default: strap_decode = {MODE_CMOS_POS, MODE_CMOS_POS}; // R12
    endcase
  endfunction

  // ==========================================================
  // Registers
  logic [7:0]       lock_sel_r;
  logic [1:0][7:0]  drv_ctrl_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lock_sel_r <= RST_LOCK_SEL;                      // R2
      drv_ctrl_r <= {RST_DRV_CTRL, RST_DRV_CTRL};
    end
    else if (ce && reg_wr_en)
    begin
      // R6
      if (reg_addr == ADDR_LOCK_SEL)
        lock_sel_r <= reg_wdata;
      else if (reg_addr == ADDR_DRV1_CTRL)
        drv_ctrl_r[0] <= reg_wdata;
      else if (reg_addr == ADDR_DRV2_CTRL)
        drv_ctrl_r[1] <= reg_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      reg_rdata <= RDATA_UNMAPPED;
    else if (ce && reg_rd_en)
    begin
      if (reg_addr == ADDR_LOCK_SEL)
        reg_rdata <= lock_sel_r;
      else if (reg_addr == ADDR_DRV1_CTRL)
        reg_rdata <= drv_ctrl_r[0];
      else if (reg_addr == ADDR_DRV2_CTRL)
        reg_rdata <= drv_ctrl_r[1];
      else
        reg_rdata <= RDATA_UNMAPPED;
    end
  end

  // ==========================================================
  // Lock pin and test port
  logic [2:0] sel;
  logic [2:0] tp_prev_r;
  logic [2:0] tp_half_r;
  logic [2:0] tp_now;

  assign sel    = lock_sel_r[SEL_MSB:SEL_LSB];
  assign tp_now = {phase_detector_fb_clk,
                   phase_detector_ref_clk,
                   phase_detector_pump_up_clk};

  // Halving on rising edges keeps the pin under half the clk rate
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tp_prev_r <= '0;
      tp_half_r <= '0;
    end
    else if (ce)
    begin
      tp_prev_r <= tp_now;
      tp_half_r <= tp_half_r ^ (tp_now & ~tp_prev_r);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      lock_pin <= 1'b0;
    else if (ce)
    begin
      if (!sel[2])
        lock_pin <= pll_locked;                        // R1
      else if (sel == TP_XTAL)
        lock_pin <= xtal_clk;                          // R3
      else if (sel == TP_PUMP)
        lock_pin <= tp_half_r[0];                      // R3
      else if (sel == TP_REF)
        lock_pin <= tp_half_r[1];                      // R3
      else
        lock_pin <= tp_half_r[2];                      // R3
    end
  end

  // ==========================================================
  // Prescaler and output dividers
  logic [3:0]              presc_ratio;
  logic                    presc_tick;
  logic [1:0]              out_level;
  logic [1:0][PX_WIDTH-1:0] px_ratio;

  always_comb
  begin
    if (vco_prescaler_ratio < PRESC_MIN)
      presc_ratio = PRESC_MIN;                         // R4
    else if (vco_prescaler_ratio > PRESC_MAX)
      presc_ratio = PRESC_MAX;                         // R4
    else
      presc_ratio = vco_prescaler_ratio;
  end

  odlc_divider #(.W(4)) u_prescaler (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .in_tick   (vco_tick),
    .ratio     (presc_ratio),
    .out_tick  (presc_tick),
    .out_level ()
  );

  assign px_ratio = {second_output_divider_ratio, first_output_divider_ratio};

  // ==========================================================
  // Output drivers
  logic [5:0]         strap_modes;
  logic [1:0][2:0]    mode;
  logic [1:0]         pin_p_nxt;
  logic [1:0]         pin_n_nxt;
  logic [1:0]         oe_p_nxt;
  logic [1:0]         oe_n_nxt;
  odlc_family_t [1:0] fam_nxt;
  logic [1:0]         pin_p_r;
  logic [1:0]         pin_n_r;
  logic [1:0]         oe_p_r;
  logic [1:0]         oe_n_r;
  odlc_family_t [1:0] fam_r;
  logic [1:0]         strong_r;

  assign strap_modes = strap_decode(output_mode_strap_pins);

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_drv
      logic [7:0] c;
      logic       t;
      assign c = drv_ctrl_r[g];

      odlc_divider #(.W(PX_WIDTH)) u_px (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .in_tick   (presc_tick),                       // R4
        .ratio     (px_ratio[g]),                      // R5
        .out_tick  (),
        .out_level (out_level[g])
      );

      always_comb
      begin
        if (c[CTL_SRC])
          mode[g] = c[MODE_MSB:MODE_LSB];              // R7
        else
          mode[g] = strap_modes[3*(1-g) +: 3];         // R7
      end

      // Static level while calibrating
      assign t = vco_cal_active ? 1'b0 : out_level[g]; // R17

      always_comb
      begin
        pin_p_nxt[g] = t;
        pin_n_nxt[g] = ~t;                             // R10
        oe_p_nxt[g]  = 1'b1;
        oe_n_nxt[g]  = 1'b1;
        fam_nxt[g]   = ODLC_FAM_CMOS;
        case (mode[g])
          MODE_CMOS_BOTH, MODE_CMOS_POS, MODE_CMOS_NEG, MODE_CMOS_OFF:
          begin
            // Both CMOS pins carry the same phase
            pin_p_nxt[g] = t ^ c[CTL_POL];             // R14
            pin_n_nxt[g] = t ^ c[CTL_POL];             // R13
            oe_p_nxt[g]  = !mode[g][1];                // R8 R9
            oe_n_nxt[g]  = !mode[g][0];                // R8 R9
          end
          MODE_LVDS:
            fam_nxt[g] = ODLC_FAM_LVDS;                // R10
          MODE_LVPECL:
            fam_nxt[g] = ODLC_FAM_LVPECL;              // R10
          default:
          begin
            fam_nxt[g]  = ODLC_FAM_NONE;
            oe_p_nxt[g] = 1'b0;                        // R18
            oe_n_nxt[g] = 1'b0;                        // R18
          end
        endcase
        if (c[CTL_PD])
        begin
          oe_p_nxt[g] = 1'b0;                          // R16
          oe_n_nxt[g] = 1'b0;                          // R16
        end
      end

      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          pin_p_r[g]  <= 1'b0;
          pin_n_r[g]  <= 1'b0;
          oe_p_r[g]   <= 1'b0;
          oe_n_r[g]   <= 1'b0;
          fam_r[g]    <= ODLC_FAM_NONE;
          strong_r[g] <= 1'b0;
        end
        else if (ce)
        begin
          pin_p_r[g]  <= pin_p_nxt[g];
          pin_n_r[g]  <= pin_n_nxt[g];
          oe_p_r[g]   <= oe_p_nxt[g];
          oe_n_r[g]   <= oe_n_nxt[g];
          fam_r[g]    <= fam_nxt[g];
          // Only CMOS and LVDS have a strength choice
          strong_r[g] <= c[CTL_DRIVE] &&
                         (fam_nxt[g] == ODLC_FAM_CMOS ||
                          fam_nxt[g] == ODLC_FAM_LVDS);  // R15
        end
      end
    end
  endgenerate

  assign first_clock_output_p       = pin_p_r[0];
  assign first_clock_output_p_oe    = oe_p_r[0];
  assign first_clock_output_n       = pin_n_r[0];
  assign first_clock_output_n_oe    = oe_n_r[0];
  assign first_clock_output_family  = fam_r[0];
  assign first_clock_output_strong  = strong_r[0];
  assign second_clock_output_p      = pin_p_r[1];
  assign second_clock_output_p_oe   = oe_p_r[1];
  assign second_clock_output_n      = pin_n_r[1];
  assign second_clock_output_n_oe   = oe_n_r[1];
  assign second_clock_output_family = fam_r[1];
  assign second_clock_output_strong = strong_r[1];

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_lock_follow: assert property ( // R1
    (ce && !sel[2]) |=> lock_pin == $past(pll_locked))
    else $error("lock pin not following lock");
  chk_sel_default: assert property ( // R2
    $fell(rst) |-> lock_sel_r[SEL_MSB:SEL_LSB] == 3'h0_0)
    else $error("test select not cleared by reset");
  chk_test_xtal: assert property ( // R3
    (ce && sel == TP_XTAL) |=> lock_pin == $past(xtal_clk))
    else $error("xtal clock not on lock pin");
  chk_strap_decode: assert property ( // R11
    (!drv_ctrl_r[0][CTL_SRC] && !drv_ctrl_r[1][CTL_SRC] &&
     output_mode_strap_pins == 3'h0_3) |->
     mode[0] == MODE_LVPECL && mode[1] == MODE_CMOS_POS)
    else $error("strap 011 decoded wrongly");
  chk_cmos_both: assert property ( // R8
    (ce && mode[0] == MODE_CMOS_BOTH && !drv_ctrl_r[0][CTL_PD]) |=>
     first_clock_output_p_oe && first_clock_output_n_oe &&
     first_clock_output_p == first_clock_output_n)
    else $error("CMOS both pins not driving alike");
  chk_cmos_neg: assert property ( // R9
    (ce && mode[1] == MODE_CMOS_NEG && !drv_ctrl_r[1][CTL_PD]) |=>
     !second_clock_output_p_oe && second_clock_output_n_oe)
    else $error("mode 010 pin enables wrong");
  chk_unused_off: assert property ( // R18
    (ce && mode[0][2:1] == 2'h3) |=>
     !first_clock_output_p_oe && !first_clock_output_n_oe)
    else $error("unused mode drove a pin");
  chk_pd_off: assert property ( // R16
    (ce && drv_ctrl_r[1][CTL_PD])[*2] |=> !second_clock_output_p_oe)
    else $error("powered-down driver still on");
  chk_cal_static: assert property ( // R17
    (ce && vco_cal_active)[*3] |=> $stable(first_clock_output_p))
    else $error("output toggled during calibration");

  cov_strap_mode: cover property (ce && !drv_ctrl_r[0][CTL_SRC] &&
                                  fam_r[0] == ODLC_FAM_LVPECL);
  cov_reg_mode: cover property (ce && drv_ctrl_r[1][CTL_SRC] &&
                                fam_r[1] == ODLC_FAM_LVDS);
  cov_test_port: cover property (ce && sel == TP_FB && $rose(lock_pin));
endmodule // odlc_output_ctrl
`default_nettype wire

// >>> bench/odlc_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module odlc_rx_model (
  input  wire logic clk,
  output logic      xtal_clk,
  output logic      pump_clk,
  output logic      ref_clk,
  output logic      fb_clk,
  output logic      vco_tick,
  input  wire logic first_p,
  input  wire logic second_p,
  output int        rise1,
  output int        rise2
);
  // ==========================================================
  // Test clocks
  // Pump shares the xtal rate; halving still makes a misrouted source show in the count
  logic [3:0] phase_r = 4'h0;
  logic       last1_r = 1'b0;
  logic       last2_r = 1'b0;

  always_ff @(posedge clk)
  begin
    phase_r <= phase_r + 4'h1;
  end

  assign xtal_clk = phase_r[1];
  assign pump_clk = phase_r[1];
  assign ref_clk  = phase_r[2];
  assign fb_clk   = phase_r[3];
  // One edge per cycle keeps the expected rates simple
  assign vco_tick = 1'b1;

  // ==========================================================
  // Receivers count rising edges
  int rise1_r = 0;
  int rise2_r = 0;

  assign rise1 = rise1_r;
  assign rise2 = rise2_r;

  always_ff @(posedge clk)
  begin
    last1_r <= first_p;
    last2_r <= second_p;
    if (first_p && !last1_r)
      rise1_r <= rise1_r + 1;
    if (second_p && !last2_r)
      rise2_r <= rise2_r + 1;
  end
endmodule // odlc_rx_model
`default_nettype wire

// >>> bench/output_driver_and_lock_port_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module output_driver_and_lock_port_control_tb;
  import odlc_pkg::*;
  // ==========================================================
  // Stimulus and design
  localparam logic [3:0] MEXP [8] = '{4'h3, 4'h2, 4'h1, 4'h0,
                                      4'h7, 4'hf, 4'h8, 4'h8};
  localparam logic [2:0] SM1 [8] = '{3'h5, 3'h5, 3'h4, 3'h5,
                                     3'h4, 3'h4, 3'h1, 3'h1};
  localparam logic [2:0] SM2 [8] = '{3'h5, 3'h4, 3'h5, 3'h1,
                                     3'h4, 3'h1, 3'h4, 3'h1};
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         ce = 1'b1;
  logic         wr = 1'b0;
  logic         rd = 1'b0;
  logic [7:0]   addr = 8'h00;
  logic [7:0]   wdata = 8'h00;
  logic         locked = 1'b0;
  logic [3:0]   presc = 4'h5;
  logic [9:0]   div1 = 10'h001;
  logic [9:0]   div2 = 10'h001;
  logic [2:0]   strap = 3'h0;
  logic         cal = 1'b0;
  logic [7:0]   rdata;
  logic         xt, pu, rf, fb, vt, lock_pin;
  logic         o1p, o1po, o1n, o1no, s1, o2p, o2po, o2n, o2no, s2;
  odlc_family_t f1, f2;
  int           r1, r2;
  int           failures = 0;
  int           check_count = 0;

  always #50 clk = ~clk;

  odlc_output_ctrl dut_u (
    .clk(clk), .rst(rst), .ce(ce), .reg_wr_en(wr), .reg_rd_en(rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .pll_locked(locked), .xtal_clk(xt), .phase_detector_pump_up_clk(pu),
    .phase_detector_ref_clk(rf), .phase_detector_fb_clk(fb),
    .lock_pin(lock_pin), .vco_tick(vt), .vco_prescaler_ratio(presc),
    .first_output_divider_ratio(div1),
    .second_output_divider_ratio(div2),
    .output_mode_strap_pins(strap), .vco_cal_active(cal),
    .first_clock_output_p(o1p), .first_clock_output_p_oe(o1po),
    .first_clock_output_n(o1n), .first_clock_output_n_oe(o1no),
    .first_clock_output_family(f1), .first_clock_output_strong(s1),
    .second_clock_output_p(o2p), .second_clock_output_p_oe(o2po),
    .second_clock_output_n(o2n), .second_clock_output_n_oe(o2no),
    .second_clock_output_family(f2), .second_clock_output_strong(s2)
  );

  odlc_rx_model model_u (
    .clk(clk), .xtal_clk(xt), .pump_clk(pu), .ref_clk(rf),
    .fb_clk(fb), .vco_tick(vt), .first_p(o1p), .second_p(o2p),
    .rise1(r1), .rise2(r2)
  );

  // ==========================================================
  // Shared tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Edge counts may slip by one with the phase of the window
  task automatic chkr(input string nm, input int e, input int g);
    check_count++;
    if (g < e - 1 || g > e + 1)
    begin
      failures++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    wr = 1'b1;
    addr = a;
    wdata = d;
    step(1);
    wr = 1'b0;
    step(2);
  endtask

  task automatic rreg(input logic [7:0] a, input logic [7:0] e,
                      input string nm);
    rd = 1'b1;
    addr = a;
    step(1);
    rd = 1'b0;
    step(1);
    chk(nm, {8'h00, e}, {8'h00, rdata});
  endtask

  task automatic chkdrv(input logic [2:0] m, input bit sec);
    logic [3:0] g;
    g = sec ? {f2, o2po, o2no} : {f1, o1po, o1no};
    chk(sec ? "drv2 family oe" : "drv1 family oe",
        {12'h000, MEXP[m]}, {12'h000, g});
  endtask

  task automatic final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    ce = 1'b0;
    wreg(ADDR_LOCK_SEL, 8'hff);
    ce = 1'b1;
    rreg(ADDR_LOCK_SEL, RST_LOCK_SEL, "lock sel");
    rreg(ADDR_DRV1_CTRL, RST_DRV_CTRL, "drv1 ctrl");
    wreg(ADDR_DRV2_CTRL, 8'ha5);
    rreg(ADDR_DRV2_CTRL, 8'ha5, "drv2 ctrl");
    wreg(8'h33, 8'h5a);
    rreg(8'h33, RDATA_UNMAPPED, "unmapped");
    wreg(ADDR_DRV2_CTRL, 8'h00);
  endtask

  task automatic t_lock;
    locked = 1'b1;
    step(2);
    chk("lock default", 16'h0001, {15'h0000, lock_pin});
    wreg(ADDR_LOCK_SEL, 8'h06);
    locked = 1'b0;
    step(2);
    chk("lock lost", 16'h0000, {15'h0000, lock_pin});
    locked = 1'b1;
    step(2);
    chk("lock held", 16'h0001, {15'h0000, lock_pin});
  endtask

  task automatic t_test;
    int   exp[4] = '{40, 20, 10, 5};
    int   n;
    logic prev;
    for (int c = 0; c < 4; c++)
    begin
      wreg(ADDR_LOCK_SEL, {4'h0, 1'b1, c[1:0], 1'b0});
      step(4);
      n = 0;
      prev = lock_pin;
      repeat (160)
      begin
        step(1);
        n += int'(lock_pin && !prev);
        prev = lock_pin;
      end
      chkr("test port rises", exp[c], n);
    end
    wreg(ADDR_LOCK_SEL, 8'h00);
  endtask

  task automatic t_strap;
    for (int s = 0; s < 8; s++)
    begin
      strap = 3'(s);
      step(4);
      chkdrv(SM1[s], 1'b0);
      chkdrv(SM2[s], 1'b1);
      if (SM1[s] == MODE_CMOS_POS)
        chk("drv1 copy", {15'h0000, o1p}, {15'h0000, o1n});
      if (SM2[s] == MODE_CMOS_POS)
        chk("drv2 copy", {15'h0000, o2p}, {15'h0000, o2n});
    end
    strap = 3'h0;
  endtask

  task automatic t_mode;
    for (int m = 0; m < 8; m++)
    begin
      wreg(ADDR_DRV1_CTRL, {2'b00, 3'(m), 3'b001});
      chkdrv(3'(m), 1'b0);
      if (m == 0)
        chk("cmos n", {15'h0000, o1p}, {15'h0000, o1n});
      if (m == 4)
        chk("lvds n", {15'h0000, ~o1p}, {15'h0000, o1n});
    end
    wreg(ADDR_DRV1_CTRL, 8'h81);
    chk("drv1 strong", 16'h0001, {15'h0000, s1});
    wreg(ADDR_DRV1_CTRL, 8'h00);
  endtask

  task automatic t_div;
    int tp0[3] = '{5, 11, 5};
    int tp1[3] = '{3, 1, 1023};
    int tp2[3] = '{7, 2, 1};
    int win[3] = '{420, 420, 10300};
    int a1, a2;
    for (int i = 0; i < 3; i++)
    begin
      presc = 4'(tp0[i]);
      div1 = 10'(tp1[i]);
      div2 = 10'(tp2[i]);
      step(40);
      a1 = r1;
      a2 = r2;
      step(win[i]);
      chkr("first rises", win[i] / (tp0[i] * tp1[i]), r1 - a1);
      chkr("second rises", win[i] / (tp0[i] * tp2[i]), r2 - a2);
    end
  endtask

  task automatic t_drive;
    logic [7:0] sd[6] = '{8'h81, 8'h01, 8'ha1, 8'h21, 8'ha9, 8'h91};
    logic       ss[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic [7:0] cd[3] = '{8'h05, 8'h01, 8'h21};
    logic [1:0] cp[3] = '{2'b11, 2'b00, 2'b01};
    for (int i = 0; i < 6; i++)
    begin
      wreg(ADDR_DRV2_CTRL, sd[i]);
      chk("drv2 strong", {15'h0000, ss[i]}, {15'h0000, s2});
    end
    wreg(ADDR_DRV2_CTRL, 8'h61);
    chk("drv2 down", 16'h0004, {12'h000, f2, o2po, o2no});
    cal = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      wreg(ADDR_DRV2_CTRL, cd[i]);
      repeat (6)
      begin
        step(1);
        chk("drv2 static", {14'h0000, cp[i]}, {14'h0000, o2p, o2n});
      end
    end
    cal = 1'b0;
  endtask

  // ==========================================================
  // Sequence and watchdog
  initial
  begin
    step(2);
    rst = 1'b0;
    step(1);
    t_regs;
    t_lock;
    t_test;
    t_strap;
    t_mode;
    t_div;
    t_drive;
    final_report;
  end

  // About two and a half times the expected run
  initial
  begin
    #3000000;
    failures++;
    final_report;
  end
endmodule // output_driver_and_lock_port_control_tb
`default_nettype wire
